/* core/hsh_defs.vh */
`ifndef HSH_DEFS_VH
`define HSH_DEFS_VH
// register byte offsets
`define HSH_OFF_CTRL 8'h00
`define HSH_OFF_STAT 8'h04
`define HSH_OFF_TEMP 8'h08
`define HSH_OFF_START 8'h0C
`define HSH_OFF_ERR 8'h10
// control register fields
`define HSH_CTRL_RESET 0
`define HSH_CTRL_PAUSE 1
`define HSH_CTRL_HEAT 2
// status register fields
`define HSH_STAT_STANDBY 0
`define HSH_STAT_FAULT 1
`define HSH_STAT_GAP 2
`define HSH_STAT_CTRLMODE 3
`define HSH_STAT_LINE 4
// error codes
`define HSH_ERR_NONE 16'h0000
`define HSH_ERR_LINE_LOST 16'h00C9
`define HSH_ERR_LINE_ACK 16'h0385
// start temperature values, degrees C, signed 16 bit
`define HSH_START_INVALID 16'hFF9D
`define HSH_START_MIN 16'hFFEC
`define HSH_START_MAX 16'h01F4
// actual value forced during alarm or calibration
`define HSH_TEMP_ZERO 16'h0000
// axi responses
`define HSH_RESP_OKAY 2'h0
`define HSH_RESP_SLVERR 2'h2
`endif

/* core/hsh_status.v */
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "hsh_defs.vh"
module hsh_status (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // plant signals, asynchronous to aclk
   input wire line_ok,
   input wire measure_taken,
   input wire calib_busy,
   // measured temperature, signed degrees, from logic on aclk
   input wire [15:0] meas_temp,
   input wire meas_valid,
   // axi4-lite write address
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // status outputs
   output reg standby_flag,
   output reg fault_flag,
   output reg measure_gap_flag,
   output reg control_mode,
   output reg [15:0] actual_temp,
   output reg [15:0] start_temp,
   output reg [15:0] error_number
);
   // register map, one 32-bit word each, byte addressed:
   //   0x00 control: bit0 reset request, bit1 pause request, bit2 heat demand
   //   0x04 status: bit0 standby, bit1 fault, bit2 gap, bit3 control mode, bit4 line present
   //   0x08 actual temperature, 0x0C start temperature, 0x10 error number
   // only the control word is writable; writes to the others are dropped with okay
   //   so a master may rewrite a full image without tripping an error
   // anything past the error word answers slverr on both paths
   // bus timing: ready pulses one cycle after valid is seen, never combinationally,
   //   which costs a cycle per beat but keeps every output a plain flop
   // write response one cycle after both beats are held, read data one after arready
   // status flags follow a control write by one cycle; pin effects lag by the
   //   two synchroniser stages plus one

   // alarm sequence states
   localparam ST_WAIT = 5'b00001;
   localparam ST_RUN = 5'b00010;
   localparam ST_LOST = 5'b00100;
   localparam ST_ACK = 5'b01000;
   localparam ST_NOLINE = 5'b10000;

   // clamp a signed temperature to the start range
   function [15:0] clamp_start;
      input [15:0] t;
      begin
         if ($signed(t) < $signed(`HSH_START_MIN)) begin
            clamp_start = `HSH_START_MIN;
         end else if ($signed(t) > $signed(`HSH_START_MAX)) begin
            clamp_start = `HSH_START_MAX;
         end else begin
            clamp_start = t;
         end
      end
   endfunction

   // alarm states share one decode so fault and the zeroed actual value agree
   function is_alarm;
      input [4:0] s;
      begin
         is_alarm = (s == ST_LOST) || (s == ST_ACK) || (s == ST_NOLINE);
      end
   endfunction

   // sequence state and the control word written by the master
   reg [4:0] state_r, state_nxt;
   reg [2:0] ctrl_r;
   // synchroniser stages for the plant pins
   reg line_s1_r, line_s2_r;
   reg meas_s1_r, meas_s2_r;
   reg cal_s1_r, cal_s2_r;
   // heat demand edge detect and temperature capture
   reg heat_d_r;
   reg [15:0] last_temp_r;
   reg [15:0] start_cap_r;
   // write beats held until both halves have arrived
   reg aw_hold_r, w_hold_r;
   reg [7:0] aw_addr_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;
   // request bits and the alarm view used by the datapath
   wire reset_request;
   wire measure_pause_request;
   wire heat_demand;
   wire alarm;

   assign reset_request = ctrl_r[`HSH_CTRL_RESET];
   assign measure_pause_request = ctrl_r[`HSH_CTRL_PAUSE];
   assign heat_demand = ctrl_r[`HSH_CTRL_HEAT];
   // alarm looks at the next state so the zeroed actual value lands with the fault flag
   assign alarm = is_alarm(state_nxt);

   // two-flop synchronisers; only the second stage is read
   // stages clear low on reset, so a pin already high at release shows up two cycles late
   always @(posedge aclk) begin
      if (!aresetn) begin
         line_s1_r <= 1'b0;
         line_s2_r <= 1'b0;
         meas_s1_r <= 1'b0;
         meas_s2_r <= 1'b0;
         cal_s1_r <= 1'b0;
         cal_s2_r <= 1'b0;
      end else begin
         line_s1_r <= line_ok;
         line_s2_r <= line_s1_r;
         meas_s1_r <= measure_taken;
         meas_s2_r <= meas_s1_r;
         cal_s1_r <= calib_busy;
         cal_s2_r <= cal_s1_r;
      end
   end

   // alarm sequence; acknowledgement is the reset request edge back to 0
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_WAIT: begin
            // standby until line voltage first appears
            if (line_s2_r) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            // normal operation, requests only touch standby
            if (!line_s2_r) begin
               state_nxt = ST_LOST;
            end
         end
         ST_LOST: begin
            // acknowledge starts with the reset request
            if (reset_request) begin
               state_nxt = ST_ACK;
            end
         end
         ST_ACK: begin
            // released: clear if line present, else error 901
            if (!reset_request) begin
               state_nxt = line_s2_r ? ST_RUN : ST_NOLINE;
            end
         end
         ST_NOLINE: begin
            // 901 stands until line is back and reset is raised again
            if (reset_request && line_s2_r) begin
               state_nxt = ST_ACK;
            end
         end
         default: begin
            // illegal codes fall back to waiting, which shows standby
            state_nxt = ST_WAIT;
         end
      endcase
   end

   // sequence register and derived flags, all straight from flops
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= ST_WAIT;
         standby_flag <= 1'b1;
         fault_flag <= 1'b0;
         control_mode <= 1'b0;
         error_number <= `HSH_ERR_NONE;
      end else begin
         state_r <= state_nxt;
         // standby: requests or first wait, one flop, no glitch state
         standby_flag <= (state_nxt == ST_WAIT) || reset_request || measure_pause_request;
         // fault persists in every alarm state until cleared
         fault_flag <= is_alarm(state_nxt);
         // control mode: running normally with heat demand
         control_mode <= (state_nxt == ST_RUN) && heat_demand;
         if (state_nxt == ST_NOLINE) begin
            error_number <= `HSH_ERR_LINE_ACK;
         end else if (state_nxt == ST_LOST) begin
            error_number <= `HSH_ERR_LINE_LOST;
         end else if (state_nxt == ST_ACK) begin
            // the code shown on entry stands until the request is released
            if (state_r != ST_ACK) begin
               error_number <= (state_r == ST_NOLINE) ? `HSH_ERR_LINE_ACK : `HSH_ERR_LINE_LOST;
            end
         end else begin
            error_number <= `HSH_ERR_NONE;
         end
      end
   end

   // measurement gap and temperatures
   always @(posedge aclk) begin
      if (!aresetn) begin
         measure_gap_flag <= 1'b0;
         actual_temp <= `HSH_TEMP_ZERO;
         start_temp <= `HSH_START_INVALID;
         last_temp_r <= `HSH_TEMP_ZERO;
         start_cap_r <= `HSH_START_INVALID;
         heat_d_r <= 1'b0;
      end else begin
         heat_d_r <= heat_demand;
         // gap follows the synchronised pin through its own flop, so it trails the plant by three cycles
         measure_gap_flag <= heat_demand && !meas_s2_r;
         if (meas_valid) begin
            last_temp_r <= meas_temp;
         end
         // latch the sample taken just before heat demand rises
         if (heat_demand && !heat_d_r) begin
            start_cap_r <= clamp_start(last_temp_r);
         end
         // first heat cycle: capture not loaded yet, so bypass it
         start_temp <= heat_demand ? ((heat_d_r) ? start_cap_r : clamp_start(last_temp_r))
                                   : `HSH_START_INVALID;
         // signed whole degrees, zero in alarm or calibration
         if (alarm || cal_s2_r) begin
            actual_temp <= `HSH_TEMP_ZERO;
         end else if (meas_valid) begin
            actual_temp <= meas_temp;
         end
      end
   end

   // axi write path: address and data taken in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `HSH_RESP_OKAY;
         ctrl_r <= 3'h0;
      end else begin
         // each ready is a one-cycle pulse, never repeated while a beat or response is held
         s_axi_awready <= !aw_hold_r && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
         s_axi_wready <= !w_hold_r && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
         // address beat
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         // data beat
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         // both beats held: apply the write and answer
         if (aw_hold_r && w_hold_r && !s_axi_bvalid) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if ({aw_addr_r[7:2], 2'b00} == `HSH_OFF_CTRL) begin
               if (w_strb_r[0]) begin
                  ctrl_r <= w_data_r[2:0];
               end
               s_axi_bresp <= `HSH_RESP_OKAY;
            end else if (aw_addr_r <= `HSH_OFF_ERR) begin
               s_axi_bresp <= `HSH_RESP_OKAY; // read-only: write ignored
            end else begin
               s_axi_bresp <= `HSH_RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            // response stood until the master took it
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // axi read path
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `HSH_RESP_OKAY;
      end else begin
         // arready pulses once; a second address waits until rvalid has gone
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `HSH_RESP_OKAY;
            case (s_axi_araddr)
               `HSH_OFF_CTRL: s_axi_rdata <= {29'h0, ctrl_r};
               `HSH_OFF_STAT: s_axi_rdata <= {27'h0, line_s2_r, control_mode, measure_gap_flag,
                                              fault_flag, standby_flag};
               `HSH_OFF_TEMP: s_axi_rdata <= {16'h0000, actual_temp};
               `HSH_OFF_START: s_axi_rdata <= {16'h0000, start_temp};
               `HSH_OFF_ERR: s_axi_rdata <= {16'h0000, error_number};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `HSH_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            // read data stood until the master took them
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

/* dv/hsh_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hsh_defs.vh"
module hsh_checker (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // plant inputs
   input wire logic line_ok,
   input wire logic measure_taken,
   input wire logic calib_busy,
   // status outputs
   input wire logic standby_flag,
   input wire logic fault_flag,
   input wire logic measure_gap_flag,
   input wire logic [15:0] actual_temp,
   input wire logic [15:0] start_temp,
   input wire logic [15:0] error_number
);
   logic seen_line_r;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // raw pin, so it leads the synchronised view inside the block
   always_ff @(posedge aclk) begin
      if (!aresetn)
         seen_line_r <= 1'b0;
      else if (line_ok)
         seen_line_r <= 1'b1;
   end
   wait_stby_a: assert property (!seen_line_r |-> standby_flag && !fault_flag)
      else $error("standby not held before first line voltage");
   line_loss_a: assert property ($fell(line_ok) && !standby_flag && !fault_flag |-> ##[1:6]
      (fault_flag && !standby_flag && error_number == `HSH_ERR_LINE_LOST)) else $error("line loss not flagged");
   alarm_hold_a: assert property (fault_flag && !standby_flag |=> fault_flag)
      else $error("fault dropped without acknowledge");
   alarm_clear_a: assert property ($fell(fault_flag) |-> $past(standby_flag) && !standby_flag)
      else $error("fault cleared outside release of acknowledge");
   err_code_a: assert property (fault_flag && $past(fault_flag) |-> error_number == `HSH_ERR_LINE_LOST
      || error_number == `HSH_ERR_LINE_ACK) else $error("unexpected error number in alarm");
   alarm_zero_a: assert property (fault_flag |-> actual_temp == `HSH_TEMP_ZERO)
      else $error("actual value not zero in alarm");
   calib_zero_a: assert property (calib_busy [*5] |-> actual_temp == `HSH_TEMP_ZERO)
      else $error("actual value not zero in calibration");
   gap_clear_a: assert property (measure_taken [*5] |-> !measure_gap_flag)
      else $error("gap flag set while measuring");
   start_range_a: assert property (start_temp == `HSH_START_INVALID || ($signed(start_temp) >= -20
      && $signed(start_temp) <= 500)) else $error("start temperature out of range");
endmodule
bind hsh_status hsh_checker u_chk (.aclk(aclk), .aresetn(aresetn), .line_ok(line_ok),
   .measure_taken(measure_taken), .calib_busy(calib_busy), .standby_flag(standby_flag),
   .fault_flag(fault_flag), .measure_gap_flag(measure_gap_flag), .actual_temp(actual_temp),
   .start_temp(start_temp), .error_number(error_number));
`default_nettype wire

/* dv/hsh_master.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hsh_defs.vh"
module hsh_master (
   // clock
   input wire logic aclk,
   // write address and data
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   // write response
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   // read address and data
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   // responses always accepted, so no ready toggling between transfers
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = 5'h03;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
   end
   // both write channels offered at once, each dropped and scrambled once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
   endtask
   // single read, answer taken at the edge rvalid is seen
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~a;
         end
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
   // raise a request, poll for standby, then withdraw it
   task automatic handshake(input logic [31:0] req, input logic [31:0] rest);
      logic [31:0] d;
      logic [1:0] r;
      wr(`HSH_OFF_CTRL, req, r);
      do
         rd(`HSH_OFF_STAT, d, r);
      while (!d[`HSH_STAT_STANDBY]);
      wr(`HSH_OFF_CTRL, rest, r);
   endtask
endmodule
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hsh_defs.vh"
module tb;
   logic aclk = 1'b0, aresetn = 1'b0, line_ok = 1'b0, measure_taken = 1'b1, calib_busy = 1'b0;
   logic meas_valid = 1'b0;
   logic [15:0] meas_temp = 16'h0000;
   wire [7:0] s_axi_awaddr, s_axi_araddr;
   wire [31:0] s_axi_wdata, s_axi_rdata;
   wire [3:0] s_axi_wstrb;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   wire standby_flag, fault_flag, measure_gap_flag, control_mode;
   wire [15:0] actual_temp, start_temp, error_number;
   int miscompares = 0, total_checks = 0;
   logic [31:0] rd_d;
   logic [1:0] rd_r;
   hsh_status u_dut (
      .aclk(aclk), .aresetn(aresetn), .line_ok(line_ok), .measure_taken(measure_taken),
      .calib_busy(calib_busy), .meas_temp(meas_temp), .meas_valid(meas_valid),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .standby_flag(standby_flag),
      .fault_flag(fault_flag), .measure_gap_flag(measure_gap_flag), .control_mode(control_mode),
      .actual_temp(actual_temp), .start_temp(start_temp), .error_number(error_number));
   hsh_master u_mst (
      .aclk(aclk), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
   always #50 aclk = ~aclk;
   task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // line_ok passes a synchroniser, so give it room before looking
   task automatic settle;
      repeat (8) @(posedge aclk);
   endtask
   task automatic ctl(input logic [31:0] d);
      u_mst.wr(`HSH_OFF_CTRL, d, rd_r);
   endtask
   // error number only means something while fault is up
   task automatic st(input logic [1:0] f, input logic [15:0] e);
      settle;
      check("flags", {14'h0, f}, {14'h0, fault_flag, standby_flag});
      if (f[1])
         check("error", e, error_number);
   endtask
   task automatic t_wait;
      st(2'b01, 16'h0);
      check("start", `HSH_START_INVALID, start_temp);
      line_ok <= 1'b1;
      st(2'b00, 16'h0);
      $display("test wait done");
   endtask
   task automatic t_pause;
      ctl(32'h2);
      st(2'b01, 16'h0);
      u_mst.rd(`HSH_OFF_STAT, rd_d, rd_r);
      check("stat", 16'h0011, rd_d[15:0]);
      ctl(32'h0);
      st(2'b00, 16'h0);
      u_mst.handshake(32'h1, 32'h0);
      st(2'b00, 16'h0);
      $display("test pause done");
   endtask
   task automatic t_temp;
      logic [15:0] in_t [3] = '{16'h0064, 16'h0258, 16'hFFE2};
      logic [15:0] ex_t [3] = '{16'h0064, 16'h01F4, 16'hFFEC};
      for (int i = 0; i < 3; i++) begin
         meas_temp <= in_t[i];
         meas_valid <= 1'b1;
         measure_taken <= 1'b0;
         settle;
         check("actual", in_t[i], actual_temp);
         ctl(32'h4);
         @(posedge aclk);
         meas_temp <= 16'h0190;
         settle;
         check("start", ex_t[i], start_temp);
         check("gap", 16'h1, {15'h0, measure_gap_flag});
         measure_taken <= 1'b1;
         settle;
         check("gap", 16'h0, {15'h0, measure_gap_flag});
         ctl(32'h0);
         settle;
         check("start", `HSH_START_INVALID, start_temp);
      end
      calib_busy <= 1'b1;
      settle;
      check("actual", `HSH_TEMP_ZERO, actual_temp);
      calib_busy <= 1'b0;
      $display("test temperature done");
   endtask
   task automatic t_loss;
      line_ok <= 1'b0;
      st(2'b10, `HSH_ERR_LINE_LOST);
      check("actual", `HSH_TEMP_ZERO, actual_temp);
      line_ok <= 1'b1;
      st(2'b10, `HSH_ERR_LINE_LOST);
      ctl(32'h1);
      st(2'b11, `HSH_ERR_LINE_LOST);
      ctl(32'h0);
      st(2'b00, 16'h0);
      $display("test line loss done");
   endtask
   task automatic t_901;
      line_ok <= 1'b0;
      st(2'b10, `HSH_ERR_LINE_LOST);
      ctl(32'h1);
      ctl(32'h0);
      settle;
      check("error", `HSH_ERR_LINE_ACK, error_number);
      check("fault", 16'h1, {15'h0, fault_flag});
      line_ok <= 1'b1;
      settle;
      ctl(32'h1);
      st(2'b11, `HSH_ERR_LINE_ACK);
      u_mst.handshake(32'h1, 32'h4);
      st(2'b00, 16'h0);
      check("control", 16'h1, {15'h0, control_mode});
      ctl(32'h0);
      $display("test acknowledge without line done");
   endtask
   task automatic t_axi;
      u_mst.rd(8'h14, rd_d, rd_r);
      check("rresp", {14'h0, `HSH_RESP_SLVERR}, {14'h0, rd_r});
      check("rdata", 16'h0, rd_d[15:0]);
      u_mst.wr(`HSH_OFF_STAT, 32'h3, rd_r);
      check("bresp", {14'h0, `HSH_RESP_OKAY}, {14'h0, rd_r});
      u_mst.wr(8'h20, 32'h1, rd_r);
      check("bresp", {14'h0, `HSH_RESP_SLVERR}, {14'h0, rd_r});
      st(2'b00, 16'h0);
      $display("test bus done");
   endtask
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_wait;
      t_pause;
      t_temp;
      t_loss;
      t_901;
      t_axi;
      give_verdict;
   end
   // run needs well under a thousand cycles
   initial begin
      #(3000 * 100);
      miscompares++;
      give_verdict;
   end
endmodule
`default_nettype wire
